// ==== hw/hpt_thermo_ctrl.v ====
// Purpose: heat pump mode choice, water targets and thermostats
// Assumes: temperature inputs synchronous to clk_sys_in
// Notes:   registers reached over APB, two-cycle transfers
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "hpt_defs.vh"

module hpt_thermo_ctrl #(
	parameter TICK_CYCLES = `HPT_TICK_NS / `HPT_CLK_PERIOD_NS
) (
	// Clock and reset
	input  wire        clk_sys_in,
	input  wire        rstn_in,
	// APB slave
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [7:0]  paddr_in,
	input  wire [31:0] pwdata_in,
	output reg  [31:0] prdata_out,
	output reg         pready_out,
	output reg         pslverr_out,
	// Temperature readings
	input  wire [7:0]  amb_temp_in,
	input  wire [7:0]  outlet_temp_in,
	input  wire [7:0]  inlet_temp_in,
	input  wire [7:0]  tank_temp_in,
	input  wire [7:0]  buf_temp_in,
	input  wire        room_thermo_on_in,
	input  wire [9:0]  zone1_adc_in,
	input  wire [9:0]  zone2_adc_in,
	// Actuators and status
	output reg         hp_on_out,
	output reg         pump_on_out,
	output reg         valve_tank_out,
	output reg         tank_heater_out,
	output reg         cooling_out,
	output reg         zone1_fault_out,
	output reg         zone2_fault_out
);

	// Sign extension to the working width
	function signed [8:0] sx;
		input [7:0] v;
		begin
			sx = {v[7], v};
		end
	endfunction

	// Qualification length per timer index
	function [7:0] qual_lim;
		input integer i;
		begin
			if (i == 0)
				qual_lim = `HPT_S_TANK_INT;
			else if (i == 1 || i == 2)
				qual_lim = `HPT_S_TANK_EXT;
			else if (i == 3)
				qual_lim = `HPT_S_OUT_QUAL;
			else
				qual_lim = `HPT_S_INL_QUAL;
		end
	endfunction

	// Register file
	reg  [31:0] ctrl;
	reg  [31:0] setpt0;
	reg  [31:0] setpt1;
	wire [31:0] status;

	wire        power    = ctrl[`HPT_CTRL_POWER];
	wire [1:0]  mode     = ctrl[`HPT_CTRL_MODE_LO+1:`HPT_CTRL_MODE_LO];
	wire        buf_sel  = ctrl[`HPT_CTRL_BUFFER];
	wire        two_zone = ctrl[`HPT_CTRL_TWO_ZONE];
	wire        int_sel  = ctrl[`HPT_CTRL_INT_SEL];
	wire        htr_en   = ctrl[`HPT_CTRL_HTR_EN];
	wire        int_use  = int_sel & htr_en;

	wire signed [8:0] h2c_raw  = sx(setpt0[7:0]);
	wire signed [8:0] c2h      = sx(setpt0[15:8]);
	wire signed [8:0] buf_dlt  = sx(setpt0[23:16]);
	wire signed [8:0] reheat   = sx(setpt0[31:24]);
	wire signed [8:0] tank_set = sx(setpt1[7:0]);
	wire signed [8:0] z1_tgt   = sx(setpt1[15:8]);
	wire signed [8:0] z2_tgt   = sx(setpt1[23:16]);

	wire signed [8:0] amb    = sx(amb_temp_in);
	wire signed [8:0] outlet = sx(outlet_temp_in);
	wire signed [8:0] inlet  = sx(inlet_temp_in);
	wire signed [8:0] tank   = sx(tank_temp_in);
	wire signed [8:0] btemp  = sx(buf_temp_in);

	// APB handshake, one wait-free access phase
	wire apb_setup  = psel_in & ~penable_in;
	wire apb_commit = psel_in & penable_in & pready_out;
	reg  [31:0] next_prdata;
	reg         next_slverr;

	// Address decode, answered in the setup cycle
	always @* begin
		next_prdata = 32'h0000_0000;
		next_slverr = 1'b0;
		if (paddr_in == `HPT_OFS_CTRL)
			next_prdata = ctrl;
		else if (paddr_in == `HPT_OFS_SETPT0)
			next_prdata = setpt0;
		else if (paddr_in == `HPT_OFS_SETPT1)
			next_prdata = setpt1;
		else if (paddr_in == `HPT_OFS_STATUS)
			next_prdata = status;
		else
			next_slverr = 1'b1;
		if (pwrite_in)
			next_prdata = 32'h0000_0000;
	end

	// Bus answer flops, pready high only in access phase
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pready_out  <= 1'b0;
			prdata_out  <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end else begin
			pready_out <= apb_setup;
			if (apb_setup) begin
				prdata_out  <= next_prdata;
				pslverr_out <= next_slverr;
			end
		end
	end

	// Register writes take effect on the completing edge only
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl   <= `HPT_CTRL_RESET;
			setpt0 <= `HPT_SETPT0_RESET;
			setpt1 <= `HPT_SETPT1_RESET;
		end else if (apb_commit && pwrite_in) begin
			if (paddr_in == `HPT_OFS_CTRL)
				ctrl <= {23'h000000, pwdata_in[8:0]};
			else if (paddr_in == `HPT_OFS_SETPT0)
				setpt0 <= pwdata_in;
			else if (paddr_in == `HPT_OFS_SETPT1)
				setpt1 <= {8'h00, pwdata_in[23:0]};
		end
	end

	// One-second tick shared by all slow timers
	reg [26:0] pre_cnt;
	reg        sec_tick;
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pre_cnt  <= 27'h0000000;
			sec_tick <= 1'b0;
		end else if (pre_cnt == TICK_CYCLES[26:0] - 27'h0000001) begin
			pre_cnt  <= 27'h0000000;
			sec_tick <= 1'b1;
		end else begin
			pre_cnt  <= pre_cnt + 27'h0000001;
			sec_tick <= 1'b0;
		end
	end

	// Changeover setpoint never below cool-to-heat plus gap
	wire signed [8:0] h2c_min = c2h + `HPT_T_CHG_GAP;
	wire signed [8:0] h2c = (h2c_raw < h2c_min) ? h2c_min : h2c_raw;

	// Auto mode decision, re-judged once an hour
	reg        auto_cool;
	reg        auto_first;
	reg [11:0] hour_cnt;
	wire       in_auto  = power & (mode == `HPT_MODE_AUTO);
	wire       hour_end = sec_tick & (hour_cnt == `HPT_S_AUTO_EVAL - 12'h001);
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			auto_cool  <= 1'b0;
			auto_first <= 1'b1;
			hour_cnt   <= 12'h000;
		end else if (!in_auto) begin
			auto_first <= 1'b1;
			hour_cnt   <= 12'h000;
		end else begin
			if (sec_tick)
				hour_cnt <= hour_end ? 12'h000 : hour_cnt + 12'h001;
			if (auto_first) begin
				auto_first <= 1'b0;
				auto_cool  <= ~(amb < h2c);
			end else if (hour_end) begin
				if (auto_cool)
					auto_cool <= (amb > c2h);
				else
					auto_cool <= ~(amb > h2c);
			end
		end
	end

	// Auto cooling compressor window, hysteresis on ambient
	reg cool_allow;
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in)
			cool_allow <= 1'b0;
		else if (amb >= `HPT_T_ACOOL_ON)
			cool_allow <= 1'b1;
		else if (amb <= `HPT_T_ACOOL_OFF)
			cool_allow <= 1'b0;
	end

	// Zone selection and targets
	wire z1_act = ctrl[`HPT_CTRL_Z1_ACT] | ~two_zone;
	wire z2_act = ctrl[`HPT_CTRL_Z2_ACT] & two_zone;
	wire room_cool = (mode == `HPT_MODE_COOL) | (in_auto & auto_cool);
	reg signed [8:0] z_hi;
	reg signed [8:0] z_lo;
	always @* begin
		z_hi = z1_tgt;
		z_lo = z1_tgt;
		if (z1_act && z2_act) begin
			z_hi = (z2_tgt > z1_tgt) ? z2_tgt : z1_tgt;
			z_lo = (z2_tgt < z1_tgt) ? z2_tgt : z1_tgt;
		end else if (z2_act) begin
			z_hi = z2_tgt;
			z_lo = z2_tgt;
		end
	end

	// Buffer and water targets
	wire signed [8:0] buf_tgt = room_cool ? z_lo : z_hi + buf_dlt;
	wire signed [8:0] wat_buf = room_cool ? z_lo - `HPT_T_BUF_COOL
	                                      : buf_tgt + `HPT_T_BUF_HEAT;
	wire signed [8:0] wat_tgt = buf_sel ? wat_buf : (room_cool ? z_lo : z_hi);

	// Room thermostat: buffer heating judged on buffer temperature
	wire buf_off = btemp > buf_tgt + `HPT_T_BUF_OFF;
	wire room_on = (buf_sel && !room_cool) ? ~buf_off : room_thermo_on_in;

	// Tank setpoints and limits
	wire signed [8:0] tank_wsp = (tank_set < `HPT_T_TANK_CAP) ? tank_set
	                                                          : `HPT_T_TANK_CAP;
	wire signed [8:0] tank_on_sp = int_use ? tank_set : tank_wsp;
	wire amb_low = amb < `HPT_T_AMB_SPLIT;
	wire signed [8:0] out_tgt  = amb_low ? `HPT_T_OUT_LOW : `HPT_T_OUT_HIGH;
	wire signed [8:0] inl_lim  = amb_low ? `HPT_T_OUT_LOW : `HPT_T_OUT_HIGH;

	// Tank-side state
	reg        tank_thermo;
	reg        water_stop;
	reg        inlet_stop;
	reg signed [8:0] inlet_at_stop;
	reg [7:0]  prerun_cnt;
	reg        int_htr;
	reg [10:0] htr_gap;
	reg [1:0]  mode_q;
	reg        power_q;
	wire       in_tank = power & (mode == `HPT_MODE_TANK);
	wire       prerun_done = (prerun_cnt >= `HPT_S_PRERUN);
	wire       hp_thermo = tank_thermo & prerun_done & ~water_stop & ~inlet_stop;

	// Continuous-duration qualifiers
	wire [4:0] qual_cond;
	wire [4:0] qual_done;
	assign qual_cond[0] = in_tank & (tank > tank_set);
	assign qual_cond[1] = in_tank & (tank > tank_set + `HPT_T_TANK_GAP);
	assign qual_cond[2] = in_tank & water_stop & (tank > tank_wsp);
	assign qual_cond[3] = in_tank & tank_thermo & (outlet > out_tgt + `HPT_T_OUT_HYST);
	assign qual_cond[4] = in_tank & tank_thermo & (inlet > inl_lim);

	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : g_qual
			reg [7:0] cnt;
			// Count seconds while held, restart on any drop
			always @(posedge clk_sys_in or negedge rstn_in) begin
				if (!rstn_in)
					cnt <= 8'h00;
				else if (!qual_cond[g])
					cnt <= 8'h00;
				else if (sec_tick && cnt < qual_lim(g))
					cnt <= cnt + 8'h01;
			end
			assign qual_done[g] = qual_cond[g] & (cnt >= qual_lim(g));
		end
	endgenerate

	// Tank thermostat on and off decisions
	wire tank_off_int = qual_done[0] | (outlet > `HPT_T_OUT_MAX);
	wire tank_off_ext = qual_done[1] | qual_done[2];
	wire tank_off = int_use ? tank_off_int : tank_off_ext;
	wire tank_on  = tank < tank_on_sp + reheat;

	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in)
			tank_thermo <= 1'b0;
		else if (!in_tank)
			tank_thermo <= 1'b0;
		else if (tank_thermo && tank_off)
			tank_thermo <= 1'b0;
		else if (!tank_thermo && tank_on)
			tank_thermo <= 1'b1;
	end

	// Pump-only lead-in after the tank thermostat turns on
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in)
			prerun_cnt <= 8'h00;
		else if (!tank_thermo)
			prerun_cnt <= 8'h00;
		else if (sec_tick && !prerun_done)
			prerun_cnt <= prerun_cnt + 8'h01;
	end

	// Heat pump water stops; inlet captured when the outlet trips
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			water_stop    <= 1'b0;
			inlet_stop    <= 1'b0;
			inlet_at_stop <= 9'h000;
		end else if (!tank_thermo) begin
			water_stop <= 1'b0;
			inlet_stop <= 1'b0;
		end else begin
			if (!water_stop && qual_done[3]) begin
				water_stop    <= 1'b1;
				inlet_at_stop <= inlet;
			end else if (water_stop && outlet < inlet_at_stop - `HPT_T_INL_HYST)
				water_stop <= 1'b0;
			if (!inlet_stop && qual_done[4])
				inlet_stop <= 1'b1;
			else if (inlet_stop && inlet < inl_lim)
				inlet_stop <= 1'b0;
		end
	end

	// Internal heater with minimum off time; gap starts elapsed
	wire htr_gap_ok = (htr_gap >= `HPT_S_HTR_GAP);
	wire htr_kill = qual_done[0] | hp_thermo | (mode != mode_q) | ~power;
	wire htr_start = in_tank & (tank < tank_set) & ~hp_thermo & htr_gap_ok & int_sel;
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			int_htr <= 1'b0;
			htr_gap <= `HPT_S_HTR_GAP;
			mode_q  <= `HPT_MODE_HEAT;
			power_q <= 1'b0;
		end else begin
			mode_q  <= mode;
			power_q <= power;
			if (int_htr && htr_kill) begin
				int_htr <= 1'b0;
				htr_gap <= 11'h000;
			end else if (!int_htr && htr_start)
				int_htr <= 1'b1;
			else if (!int_htr && sec_tick && !htr_gap_ok)
				htr_gap <= htr_gap + 11'h001;
		end
	end

	// Zone sensor open and short detection, two-zone only
	wire z1_bad = (zone1_adc_in >= `HPT_ADC_OPEN) | (zone1_adc_in <= `HPT_ADC_SHORT);
	wire z2_bad = (zone2_adc_in >= `HPT_ADC_OPEN) | (zone2_adc_in <= `HPT_ADC_SHORT);

	// Actuator decisions
	reg next_hp;
	reg next_pump;
	reg next_valve;
	always @* begin
		next_hp    = 1'b0;
		next_pump  = 1'b0;
		next_valve = 1'b0;
		if (in_tank) begin
			next_valve = tank_thermo;
			next_pump  = tank_thermo;
			next_hp    = hp_thermo;
		end else if (power && room_on) begin
			next_pump = 1'b1;
			next_hp   = ~(in_auto & auto_cool & ~cool_allow);
		end
		// Room thermostat off leaves both off in room modes
		if (!in_tank && !room_on) begin
			next_hp   = 1'b0;
			next_pump = 1'b0;
		end
	end

	// Registered outputs
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hp_on_out       <= 1'b0;
			pump_on_out     <= 1'b0;
			valve_tank_out  <= 1'b0;
			tank_heater_out <= 1'b0;
			cooling_out     <= 1'b0;
			zone1_fault_out <= 1'b0;
			zone2_fault_out <= 1'b0;
		end else begin
			hp_on_out       <= next_hp;
			pump_on_out     <= next_pump;
			valve_tank_out  <= next_valve;
			tank_heater_out <= int_htr;
			cooling_out     <= room_cool & ~in_tank;
			zone1_fault_out <= two_zone & z1_bad;
			zone2_fault_out <= two_zone & z2_bad;
		end
	end

	// Status word, live state of the block
	assign status = {7'h00, buf_tgt[7:0], wat_tgt[7:0], zone2_fault_out,
	                 zone1_fault_out, tank_thermo, int_htr, valve_tank_out,
	                 pump_on_out, hp_on_out, cooling_out, power_q};

endmodule // hpt_thermo_ctrl

// ==== hw/hpt_defs.vh ====
// What this block does
// - Room thermostat off stops heat pump and pump
// - Two zones: heat takes higher, cool lower
// - Flag open or short zone sensors
// - Buffer target: higher plus delta, or lower
// - Water target: buffer plus 2, lower minus 3
// - Buffer heating: room off above buffer target
// - Heat-to-cool kept 1 above cool-to-heat
// - Auto: on entry, heat below heat-to-cool, else cool
// - Auto hold-or-swap decision per current mode
// - Auto decision taken once every 60 minutes
// - Auto cooling runs between 19 and 16 degrees
// - Valve to tank while tank thermostat on
// - Internal heater: off after 15 s or 75
// - Otherwise off after 20 s above limits
// - Tank on below setpoint plus re-heat offset
// - Pump runs 3 minutes before heat pump
// - Tank water setpoint capped at 51
// - Outlet target 55 below 5, else 57
// - Outlet stop after 3 min, restart inlet minus 3
// - Inlet above 57/55 for 30 s stops
// - Internal heater on conditions, 20 min gap
// - Internal heater off conditions
//
// Purpose: constants of the heat pump mode and thermostat controller
// Assumes: temperatures are signed whole degrees C, 8 bits
// Notes:   definitions only
`ifndef HPT_DEFS_VH
`define HPT_DEFS_VH

// APB register byte offsets
`define HPT_OFS_CTRL      8'h00
`define HPT_OFS_SETPT0    8'h04
`define HPT_OFS_SETPT1    8'h08
`define HPT_OFS_STATUS    8'h0C

// Control register fields
`define HPT_CTRL_POWER    0
`define HPT_CTRL_MODE_LO  1
`define HPT_CTRL_BUFFER   3
`define HPT_CTRL_TWO_ZONE 4
`define HPT_CTRL_INT_SEL  5
`define HPT_CTRL_Z1_ACT   6
`define HPT_CTRL_Z2_ACT   7
`define HPT_CTRL_HTR_EN   8
`define HPT_CTRL_RESET    32'h0000_0000
`define HPT_SETPT0_RESET  32'h0005_0F14
`define HPT_SETPT1_RESET  32'h0023_2330

// Operating modes
`define HPT_MODE_HEAT     2'h0
`define HPT_MODE_COOL     2'h1
`define HPT_MODE_AUTO     2'h2
`define HPT_MODE_TANK     2'h3

// Temperature figures in degrees C
// Signed, so compares against sub-zero readings stay signed
`define HPT_T_BUF_HEAT    9'sh002
`define HPT_T_BUF_COOL    9'sh003
`define HPT_T_BUF_OFF     9'sh000
`define HPT_T_CHG_GAP     9'sh001
`define HPT_T_ACOOL_ON    9'sh013
`define HPT_T_ACOOL_OFF   9'sh010
`define HPT_T_OUT_MAX     9'sh04B
`define HPT_T_TANK_GAP    9'sh001
`define HPT_T_TANK_CAP    9'sh033
`define HPT_T_AMB_SPLIT   9'sh005
`define HPT_T_OUT_LOW     9'sh037
`define HPT_T_OUT_HIGH    9'sh039
`define HPT_T_OUT_HYST    9'sh002
`define HPT_T_INL_HYST    9'sh003

// Zone sensor ADC limits
`define HPT_ADC_OPEN      10'h3F0
`define HPT_ADC_SHORT     10'h00F

// Times, seconds unless named otherwise
`define HPT_CLK_PERIOD_NS 10
`define HPT_TICK_NS       1000000000
`define HPT_S_TANK_INT    8'h0F
`define HPT_S_TANK_EXT    8'h14
`define HPT_S_OUT_QUAL    8'hB4
`define HPT_S_INL_QUAL    8'h1E
`define HPT_S_PRERUN      8'hB4
`define HPT_S_HTR_GAP     11'h4B0
`define HPT_S_AUTO_EVAL   12'hE10

`endif

// ==== tb/hpt_plant_model.sv ====
// Purpose: water circuit seen by the controller's actuators
// Assumes: compressor lift of 5 degrees only with flow
// Notes:   outlet follows inlet, one cycle late like a real sensor
`timescale 1ns/100ps

module hpt_plant_model (
	// Clock and reset
	input  wire        clk_sys_in,
	input  wire        rstn_in,
	// Actuators and inlet reading
	input  wire        hp_on_in,
	input  wire        pump_on_in,
	input  wire [7:0]  inlet_temp_in,
	// Outlet reading
	output logic [7:0] outlet_temp_out
);
	// No lift without flow, so a stalled pump never shows hot water
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			outlet_temp_out <= 8'h14;
		end else begin
			outlet_temp_out <= (hp_on_in && pump_on_in) ? inlet_temp_in + 8'h05 : inlet_temp_in;
		end
	end
endmodule // hpt_plant_model

// ==== tb/hpt_thermo_ctrl_props.sv ====
// Purpose: port-level checks of the thermo controller
// Assumes: CTRL shadowed from completed APB writes
// Notes:   bound to every instance of the controller
`timescale 1ns/100ps

module hpt_thermo_props #(
	parameter TICK_CYCLES = 10
) (
	input wire        clk_sys_in,
	input wire        rstn_in,
	input wire        psel_in,
	input wire        penable_in,
	input wire        pwrite_in,
	input wire [7:0]  paddr_in,
	input wire [31:0] pwdata_in,
	input wire        pready_out,
	input wire        pslverr_out,
	input wire        room_thermo_on_in,
	input wire [9:0]  zone1_adc_in,
	input wire        hp_on_out,
	input wire        pump_on_out,
	input wire        valve_tank_out,
	input wire        tank_heater_out,
	input wire        zone1_fault_out
);
	localparam int PRERUN = 179 * TICK_CYCLES;
	logic [8:0]  ctrl;
	logic [31:0] pump_cnt;
	wire         tank_m = (ctrl[2:1] == 2'h3);
	// Shadow CTRL and pump run length; slack of one tick for rounding
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl     <= 9'h000;
			pump_cnt <= 32'h0;
		end else begin
			if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == 8'h00)
				ctrl <= pwdata_in[8:0];
			pump_cnt <= pump_on_out ? pump_cnt + 32'h1 : 32'h0;
		end
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	a_pready_one_pulse: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
		else $error("pready not one pulse after setup");
	a_unmapped_err: assert property (psel_in && !penable_in && paddr_in > 8'h0C |=> pslverr_out)
		else $error("no slave error on unmapped address");
	a_hp_needs_pump: assert property (hp_on_out |-> pump_on_out)
		else $error("heat pump on without water pump");
	a_room_off_stops: assert property ((!tank_m && !ctrl[3] && !room_thermo_on_in)[*3] |-> !hp_on_out && !pump_on_out)
		else $error("room demand off but actuators on");
	a_zone_open_flag: assert property ((ctrl[4] && zone1_adc_in >= 10'h3F0)[*3] |-> zone1_fault_out)
		else $error("open zone sensor not flagged");
	a_valve_tank_only: assert property ((!tank_m)[*3] |-> !valve_tank_out && !tank_heater_out)
		else $error("tank side active outside tank mode");
	a_prerun_hold: assert property ($rose(hp_on_out) && valve_tank_out |-> pump_cnt >= PRERUN)
		else $error("heat pump started before pump prerun");
	a_heater_yields: assert property (hp_on_out[*3] |-> !tank_heater_out)
		else $error("tank heater on with heat pump on");
	cover property ($rose(valve_tank_out));
	cover property ($fell(hp_on_out) && pump_on_out);
	cover property ($rose(zone1_fault_out));
endmodule // hpt_thermo_props

bind hpt_thermo_ctrl hpt_thermo_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (
	.clk_sys_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
	.pready_out, .pslverr_out, .room_thermo_on_in, .zone1_adc_in, .hp_on_out,
	.pump_on_out, .valve_tank_out, .tank_heater_out, .zone1_fault_out);

// ==== tb/tb_heatpump_mode_thermo_ctrl.sv ====
// Purpose: self-checking run of the thermo controller
// Assumes: one second shortened to ten cycles
// Notes:   random zone targets from a fixed seed
`timescale 1ns/100ps
`include "hpt_defs.vh"

module tb_heatpump_mode_thermo_ctrl;
	localparam TICK = 10;
	localparam logic [9:0] ADC_T [4] = '{10'h3F0, 10'h00F, 10'h3EF, 10'h010};
	logic        clk_sys_in, rstn_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
	logic        room_thermo_on_in, hp_on_out, pump_on_out, valve_tank_out, err;
	logic        tank_heater_out, cooling_out, zone1_fault_out, zone2_fault_out, h, bp;
	logic [7:0]  paddr_in, amb_temp_in, outlet_temp_in, inlet_temp_in, tank_temp_in;
	logic [7:0]  buf_temp_in, z1, z2, dl;
	logic [9:0]  zone1_adc_in, zone2_adc_in;
	logic [31:0] pwdata_in, prdata_out, rd;
	integer      failures = 0, compares = 0, cyc = 0, seed = 32'hfa684a8c, n, i;

	hpt_thermo_ctrl #(.TICK_CYCLES(TICK)) i_dut (.clk_sys_in, .rstn_in, .psel_in, .penable_in,
		.pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .amb_temp_in,
		.outlet_temp_in, .inlet_temp_in, .tank_temp_in, .buf_temp_in, .room_thermo_on_in,
		.zone1_adc_in, .zone2_adc_in, .hp_on_out, .pump_on_out, .valve_tank_out,
		.tank_heater_out, .cooling_out, .zone1_fault_out, .zone2_fault_out);
	hpt_plant_model i_plant (.clk_sys_in, .rstn_in, .hp_on_in(hp_on_out),
		.pump_on_in(pump_on_out), .inlet_temp_in, .outlet_temp_out(outlet_temp_in));

	// Free-running system clock
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	// Hang guard, well above the longest wait
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			tally_and_finish;
		end
	end

	task tally_and_finish;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// APB master: hold request until pready seen at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		integer k;
		k = 0;
		@(posedge clk_sys_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= w;
		paddr_in   <= a;
		pwdata_in  <= d;
		@(posedge clk_sys_in);
		penable_in <= 1'b1;
		@(posedge clk_sys_in);
		while (pready_out !== 1'b1 && k < 50) begin
			@(posedge clk_sys_in);
			k++;
		end
		if (k == 50)
			failures++;
		rd  = prdata_out;
		err = pslverr_out;
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
	endtask
	// Outputs read at the edge, so the values seen are the settled ones
	task cycles(input integer c);
		repeat (c) @(posedge clk_sys_in);
	endtask
	function logic [7:0] f_buf(input logic ht, input logic [7:0] a, b, d);
		return ht ? ((a > b ? a : b) + d) : (a < b ? a : b);
	endfunction
	function logic [7:0] f_water(input logic ht, input logic bb, input logic [7:0] a, b, d);
		if (!bb)
			return ht ? (a > b ? a : b) : (a < b ? a : b);
		return ht ? f_buf(1'b1, a, b, d) + 8'h02 : f_buf(1'b0, a, b, d) - 8'h03;
	endfunction

	// Main sequence
	initial begin
		{rstn_in, psel_in, penable_in, pwrite_in, room_thermo_on_in} = 5'h00;
		{paddr_in, pwdata_in} = 40'h0;
		{amb_temp_in, inlet_temp_in, tank_temp_in, buf_temp_in} = 32'h0A28_3414;
		{zone1_adc_in, zone2_adc_in} = 20'h80200;
		repeat (20) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		apb(1'b0, `HPT_OFS_CTRL, 32'h0);
		chk(rd, `HPT_CTRL_RESET, "ctrl reset");
		apb(1'b0, `HPT_OFS_SETPT0, 32'h0);
		chk(rd, `HPT_SETPT0_RESET, "setpt0 reset");
		apb(1'b0, `HPT_OFS_SETPT1, 32'h0);
		chk(rd, `HPT_SETPT1_RESET, "setpt1 reset");
		apb(1'b0, 8'h10, 32'h0);
		chk({rd[30:0], err}, 32'h1, "unmapped read");
		// Zone sensor limits, both sides of each
		apb(1'b1, `HPT_OFS_CTRL, 32'h0000_0011);
		for (i = 0; i < 4; i++) begin
			@(posedge clk_sys_in);
			zone1_adc_in <= ADC_T[i];
			zone2_adc_in <= ADC_T[3 - i];
			cycles(4);
			chk({zone1_fault_out, zone2_fault_out}, {i < 2, i >= 2}, "zone fault");
		end
		zone1_adc_in <= 10'h100 + 10'($random(seed) & 32'h1FF);
		// Random zone targets over heat, cool, buffer
		for (i = 0; i < 8; i++) begin
			h  = !i[0];
			bp = i[1];
			z1 = 8'h14 + 8'($random(seed) & 32'h1F);
			z2 = 8'h14 + 8'($random(seed) & 32'h1F);
			dl = 8'($random(seed) & 32'h07);
			apb(1'b1, `HPT_OFS_SETPT0, {8'h00, dl, 16'h0F14});
			apb(1'b1, `HPT_OFS_SETPT1, {8'h00, z2, z1, 8'h30});
			apb(1'b1, `HPT_OFS_CTRL, {28'h000_000D, bp, 1'b0, !h, 1'b1});
			cycles(4);
			apb(1'b0, `HPT_OFS_STATUS, 32'h0);
			chk(rd[16:9], f_water(h, bp, z1, z2, dl), "water target");
			if (bp)
				chk(rd[24:17], f_buf(h, z1, z2, dl), "buffer target");
		end
		// Room demand dropped in single zone heating
		apb(1'b1, `HPT_OFS_CTRL, 32'h0000_0041);
		room_thermo_on_in <= 1'b1;
		cycles(10);
		chk({hp_on_out, pump_on_out}, 2'h3, "room on");
		room_thermo_on_in <= 1'b0;
		cycles(4);
		chk({hp_on_out, pump_on_out}, 2'h0, "room off");
		// Auto entered from cooling; changeover gap widens heat-to-cool
		apb(1'b1, `HPT_OFS_CTRL, 32'h0000_0043);
		apb(1'b1, `HPT_OFS_SETPT0, 32'h0005_0F0A);
		amb_temp_in <= 8'h0E;
		apb(1'b1, `HPT_OFS_CTRL, 32'h0000_0045);
		cycles(5);
		chk(cooling_out, 1'b0, "auto heat");
		amb_temp_in <= 8'h10;
		cycles(100);
		chk(cooling_out, 1'b0, "auto held");
		n = 0;
		while (cooling_out !== 1'b1 && n < 37000) begin
			cycles(1);
			n++;
		end
		chk(n > 35000 && cooling_out === 1'b1, 1'b1, "auto hourly swap");
		room_thermo_on_in <= 1'b1;
		cycles(5);
		chk({hp_on_out, pump_on_out}, 2'h1, "auto cool held off");
		amb_temp_in <= 8'h13;
		cycles(5);
		chk({hp_on_out, pump_on_out}, 2'h3, "auto cool run");
		// Tank mode: capped setpoint keeps a warm tank off
		apb(1'b1, `HPT_OFS_SETPT0, 32'h0005_0F14);
		apb(1'b1, `HPT_OFS_SETPT1, 32'h0023_233C);
		apb(1'b1, `HPT_OFS_CTRL, 32'h0000_0047);
		amb_temp_in  <= 8'h0A;
		tank_temp_in <= 8'h34;
		cycles(20);
		chk(valve_tank_out, 1'b0, "cap");
		apb(1'b1, `HPT_OFS_SETPT1, 32'h0023_2330);
		tank_temp_in <= 8'h28;
		cycles(5);
		chk({valve_tank_out, pump_on_out, hp_on_out}, 3'h6, "tank on");
		n = 0;
		while (hp_on_out !== 1'b1 && n < 2500) begin
			cycles(1);
			n++;
		end
		chk(n >= 1785 && n <= 1800, 1'b1, "prerun");
		inlet_temp_in <= 8'h3A;
		n = 0;
		while (hp_on_out !== 1'b0 && n < 400) begin
			cycles(1);
			n++;
		end
		chk(n >= 295 && n <= 310 && pump_on_out === 1'b1, 1'b1, "inlet stop");
		inlet_temp_in <= 8'h32;
		cycles(10);
		chk(hp_on_out, 1'b1, "inlet restart");
		tank_temp_in <= 8'h32;
		cycles(150);
		tank_temp_in <= 8'h28;
		cycles(5);
		tank_temp_in <= 8'h32;
		cycles(150);
		chk(valve_tank_out, 1'b1, "qualifier restarted");
		cycles(60);
		chk({valve_tank_out, pump_on_out, hp_on_out}, 3'h0, "tank off");
		tally_and_finish;
	end
endmodule // tb_heatpump_mode_thermo_ctrl
